// ===== shared/spg_pkg.sv
// Constants, field layout and types of the four-channel strobe pulse generator.
// Assumes quadlet (32-bit) register access at byte offsets within the strobe register space.
package spg_pkg;

  localparam int SPG_NUM_CH = 4;
  localparam int SPG_CNT_W = 12;
  localparam int SPG_ADDR_W = 12;

  // Byte offsets of the four control quadlets
  localparam logic [SPG_ADDR_W-1:0] SPG_CTRL_A_OFS = 12'h200;
  localparam logic [SPG_ADDR_W-1:0] SPG_CTRL_B_OFS = 12'h204;
  localparam logic [SPG_ADDR_W-1:0] SPG_CTRL_C_OFS = 12'h208;
  localparam logic [SPG_ADDR_W-1:0] SPG_CTRL_D_OFS = 12'h20c;

  // Field positions; the host counts bit 0 as the MSB, so host bit b sits at 31-b here
  localparam int SPG_PRESENT_BIT = 31;
  localparam int SPG_ENABLE_BIT = 25;
  localparam int SPG_POLARITY_BIT = 24;
  localparam int SPG_DELAY_LSB = 12;
  localparam int SPG_DUR_LSB = 0;

  // Reset values
  localparam logic SPG_PRESENT_VAL = 1'b1;
  localparam logic SPG_ENABLE_RST = 1'b0;
  localparam logic SPG_POLARITY_RST = 1'b1;
  localparam logic [SPG_CNT_W-1:0] SPG_DELAY_RST = 12'h000;
  localparam logic [SPG_CNT_W-1:0] SPG_DUR_RST = 12'hfff;
  localparam logic [SPG_CNT_W-1:0] SPG_CNT_ZERO = 12'h000;
  localparam logic [SPG_CNT_W-1:0] SPG_CNT_ONE = 12'h001;
  localparam logic [31:0] SPG_READ_ZERO = 32'h0000_0000;

  typedef logic [SPG_CNT_W-1:0] spg_cnt_t;

  // Gray sequence along idle -> delay -> active
  typedef enum logic [1:0] {
    SPG_IDLE = 2'b00,
    SPG_DELAY = 2'b01,
    SPG_ACTIVE = 2'b11
  } spg_state_e;

  // Quadlet-aligned hit on one of the four control registers
  function automatic logic spg_hit(input logic [SPG_ADDR_W-1:0] addr);
    return (addr == SPG_CTRL_A_OFS) || (addr == SPG_CTRL_B_OFS) ||
           (addr == SPG_CTRL_C_OFS) || (addr == SPG_CTRL_D_OFS);
  endfunction

  function automatic logic [1:0] spg_index(input logic [SPG_ADDR_W-1:0] addr);
    return addr[3:2];
  endfunction

endpackage

// ===== shared/spg_chan_if.sv
// Per-channel bundle between the register file in the top and one pulse timer.
// Assumes one instance per strobe channel, all on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface spg_chan_if;
  import spg_pkg::*;
  logic en;
  logic pol;
  spg_cnt_t delay;
  spg_cnt_t dur;
  logic trig;
  logic dly_tick;
  logic dur_tick;
  logic active;
  modport regs (output en, output pol, output delay, output dur, output trig, output dly_tick,
                output dur_tick, input active);
  modport timer (input en, input pol, input delay, input dur, input trig, input dly_tick,
                 input dur_tick, output active);
endinterface
`default_nettype wire

// ===== design/spg_pulse_timer.sv
// One strobe channel: delay countdown after the reference event, then the active phase.
// Assumes the time-base ticks are one-cycle pulses from the surrounding camera logic.
`timescale 1ns/1ps
`default_nettype none
module spg_pulse_timer import spg_pkg::*; (
  input wire logic clk, // System clock
  input wire logic reset, // Asynchronous reset, active high
  spg_chan_if.timer chan // Channel configuration and status
);
  spg_state_e state, next_state;
  spg_cnt_t cnt, next_cnt;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      SPG_IDLE: begin
        // A trigger while busy is dropped; one pulse per reference event
        if (chan.en && chan.trig) begin
          if (chan.delay != SPG_CNT_ZERO) begin
            next_state = SPG_DELAY;
            next_cnt = chan.delay;
          end else if (chan.dur != SPG_CNT_ZERO) begin
            next_state = SPG_ACTIVE;
            next_cnt = chan.dur;
          end
        end
      end
      SPG_DELAY: begin
        if (chan.dly_tick) begin
          if (cnt == SPG_CNT_ONE) begin
            next_state = (chan.dur != SPG_CNT_ZERO) ? SPG_ACTIVE : SPG_IDLE;
            next_cnt = chan.dur;
          end else begin
            next_cnt = cnt - SPG_CNT_ONE;
          end
        end
      end
      SPG_ACTIVE: begin
        if (chan.dur_tick) begin
          if (cnt == SPG_CNT_ONE) begin
            next_state = SPG_IDLE;
            next_cnt = SPG_CNT_ZERO;
          end else begin
            next_cnt = cnt - SPG_CNT_ONE;
          end
        end
      end
      default: begin
        next_state = SPG_IDLE;
        next_cnt = SPG_CNT_ZERO;
      end
    endcase
    // Switching the strobe off aborts any pulse in flight
    if (!chan.en) begin
      next_state = SPG_IDLE;
      next_cnt = SPG_CNT_ZERO;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= SPG_IDLE;
      cnt <= SPG_CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign chan.active = (state == SPG_ACTIVE);
endmodule // spg_pulse_timer
`default_nettype wire

// ===== design/spg_port_mux.sv
// Routes each enabled strobe to its own output port when that port is set to carry the strobe.
// Assumes the top registers the result; this module is purely combinational.
`timescale 1ns/1ps
`default_nettype none
module spg_port_mux import spg_pkg::*; (
  input wire logic [SPG_NUM_CH-1:0] en, // Strobe switched on
  input wire logic [SPG_NUM_CH-1:0] pol, // Active level, 1 = high
  input wire logic [SPG_NUM_CH-1:0] active, // Timer in active phase
  input wire logic [SPG_NUM_CH-1:0] sel, // Port configured for strobe
  input wire logic [SPG_NUM_CH-1:0] other, // Level from the port's other function
  output logic [SPG_NUM_CH-1:0] port_out // Level for each physical port
);
  always_comb begin
    port_out = other;
    for (int i = 0; i < SPG_NUM_CH; i++) begin
      // Strobe n only ever reaches port n, and only with both enable and select set
      if (sel[i] && en[i]) begin
        port_out[i] = active[i] ? pol[i] : ~pol[i];
      end
    end
  end
endmodule // spg_port_mux
`default_nettype wire

// ===== design/spg_strobe_top.sv
// Four-channel strobe pulse generator: control registers, reference event, timers, port routing.
// Assumes a quadlet register port decoded from the host register space, synchronous inputs,
// and time-base tick pulses supplied by the surrounding camera logic.
//
// Contract
// - Top bit of each control register reads 1, read only, showing presence.
// - Enable bit switches the strobe off at 0, on at 1; resets to 0.
// - While enable is 0, writes to all other fields are ignored.
// - Polarity bit: 0 active low, 1 active high; resets to 1.
// - Twelve-bit delay field accepts 0 to 4095, resets to 0.
// - Strobe asserts after delay count times the delay time base.
// - Twelve-bit duration field accepts 0 to 4095, resets to 4095.
// - Strobe stays active for duration count times the duration time base.
// - Three more identical control registers sit at 0x204, 0x208, 0x20C.
// - Strobe n appears only on port n, and only if configured for strobe.
// - Host bit 0 is the most significant bit of the quadlet.
`timescale 1ns/1ps
`default_nettype none
module spg_strobe_top import spg_pkg::*; (
  input wire logic CLK, // System clock, 50 MHz
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic [SPG_ADDR_W-1:0] REG_ADDR, // Byte offset of the quadlet
  input wire logic REG_WR, // Write strobe, one cycle
  input wire logic REG_RD, // Read strobe, one cycle
  input wire logic [31:0] REG_WDATA, // Write quadlet
  input wire logic EXPOSURE_START, // Exposure level; rising edge is the reference event
  input wire logic DELAY_TICK, // Delay time base tick
  input wire logic DURATION_TICK, // Duration time base tick
  input wire logic [SPG_NUM_CH-1:0] PORT_STROBE_SEL, // Port n configured for strobe
  input wire logic [SPG_NUM_CH-1:0] PORT_LEVEL, // Port level when not carrying strobe
  output logic [31:0] REG_RDATA, // Read quadlet, held until next read
  output logic REG_ACK, // Access done, one cycle
  output logic [SPG_NUM_CH-1:0] OUT_PORT // Physical output ports
);
  logic [SPG_NUM_CH-1:0] en, next_en;
  logic [SPG_NUM_CH-1:0] pol, next_pol;
  spg_cnt_t dly [SPG_NUM_CH];
  spg_cnt_t next_dly [SPG_NUM_CH];
  spg_cnt_t dur [SPG_NUM_CH];
  spg_cnt_t next_dur [SPG_NUM_CH];
  logic [31:0] next_rdata;
  logic next_ack;
  logic exp_q, next_exp_q;
  logic trig;
  logic [SPG_NUM_CH-1:0] active;
  logic [SPG_NUM_CH-1:0] port_mux;
  logic [1:0] idx;

  assign idx = spg_index(REG_ADDR);

  // Register writes
  always_comb begin
    next_en = en;
    next_pol = pol;
    for (int i = 0; i < SPG_NUM_CH; i++) begin
      next_dly[i] = dly[i];
      next_dur[i] = dur[i];
    end
    if (REG_WR && spg_hit(REG_ADDR)) begin
      next_en[idx] = REG_WDATA[SPG_ENABLE_BIT];
      // Fields other than enable are frozen while the strobe is off
      if (en[idx]) begin
        next_pol[idx] = REG_WDATA[SPG_POLARITY_BIT];
        next_dly[idx] = REG_WDATA[SPG_DELAY_LSB +: SPG_CNT_W];
        next_dur[idx] = REG_WDATA[SPG_DUR_LSB +: SPG_CNT_W];
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      en <= {SPG_NUM_CH{SPG_ENABLE_RST}};
      pol <= {SPG_NUM_CH{SPG_POLARITY_RST}};
      for (int i = 0; i < SPG_NUM_CH; i++) begin
        dly[i] <= SPG_DELAY_RST;
        dur[i] <= SPG_DUR_RST;
      end
    end else begin
      en <= next_en;
      pol <= next_pol;
      for (int i = 0; i < SPG_NUM_CH; i++) begin
        dly[i] <= next_dly[i];
        dur[i] <= next_dur[i];
      end
    end
  end

  // Readback; a read in the same cycle as a write returns the old contents
  always_comb begin
    next_rdata = REG_RDATA;
    next_ack = REG_RD || REG_WR;
    if (REG_RD) begin
      next_rdata = SPG_READ_ZERO;
      if (spg_hit(REG_ADDR)) begin
        next_rdata[SPG_PRESENT_BIT] = SPG_PRESENT_VAL;
        next_rdata[SPG_ENABLE_BIT] = en[idx];
        next_rdata[SPG_POLARITY_BIT] = pol[idx];
        next_rdata[SPG_DELAY_LSB +: SPG_CNT_W] = dly[idx];
        next_rdata[SPG_DUR_LSB +: SPG_CNT_W] = dur[idx];
      end
    end
  end

  // Reference event: rising edge of the exposure level
  assign next_exp_q = EXPOSURE_START;
  assign trig = EXPOSURE_START && !exp_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= SPG_READ_ZERO;
      REG_ACK <= 1'b0;
      exp_q <= 1'b0;
      OUT_PORT <= {SPG_NUM_CH{1'b0}};
    end else begin
      REG_RDATA <= next_rdata;
      REG_ACK <= next_ack;
      exp_q <= next_exp_q;
      OUT_PORT <= port_mux;
    end
  end

  spg_chan_if chan [SPG_NUM_CH] ();

  for (genvar g = 0; g < SPG_NUM_CH; g++) begin : g_ch
    assign chan[g].en = en[g];
    assign chan[g].pol = pol[g];
    assign chan[g].delay = dly[g];
    assign chan[g].dur = dur[g];
    assign chan[g].trig = trig;
    assign chan[g].dly_tick = DELAY_TICK;
    assign chan[g].dur_tick = DURATION_TICK;
    assign active[g] = chan[g].active;

    spg_pulse_timer u_timer (
      .clk(CLK),
      .reset(RESET),
      .chan(chan[g].timer)
    );
  end

  spg_port_mux u_mux (
    .en(en),
    .pol(pol),
    .active(active),
    .sel(PORT_STROBE_SEL),
    .other(PORT_LEVEL),
    .port_out(port_mux)
  );
endmodule // spg_strobe_top
`default_nettype wire

// ===== bench/spg_flash_model.sv
// Flash unit on output port 0: measures each high pulse in clock cycles.
// Assumes it only listens; the block drives the port at all times.
`timescale 1ns/1ps
`default_nettype none
module spg_flash_model (
  input wire logic clk, // System clock
  input wire logic lvl, // Port level seen by the flash
  output int width // Length of the last pulse
);
  int run = 0;
  always @(posedge clk) begin
    if (lvl === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule // spg_flash_model
`default_nettype wire

// ===== bench/spg_strobe_properties.sv
// Concurrent checks on the strobe generator's top-level ports.
// Assumes the bench holds PORT_STROBE_SEL at zero through reset.
`timescale 1ns/1ps
`default_nettype none
module spg_strobe_properties import spg_pkg::*; (
  input wire logic CLK, // System clock
  input wire logic RESET, // Asynchronous reset
  input wire logic [SPG_ADDR_W-1:0] REG_ADDR, // Quadlet offset
  input wire logic REG_WR, // Write strobe
  input wire logic REG_RD, // Read strobe
  input wire logic EXPOSURE_START, // Reference level
  input wire logic DELAY_TICK, // Delay tick
  input wire logic DURATION_TICK, // Duration tick
  input wire logic [SPG_NUM_CH-1:0] PORT_STROBE_SEL, // Strobe routing
  input wire logic [SPG_NUM_CH-1:0] PORT_LEVEL, // Other level
  input wire logic [31:0] REG_RDATA, // Read quadlet
  input wire logic REG_ACK, // Access done
  input wire logic [SPG_NUM_CH-1:0] OUT_PORT // Port levels
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic hit;
  assign hit = (REG_ADDR[11:4] == 8'h20) && (REG_ADDR[1:0] == 2'b00);
  sequence s_req; REG_WR || REG_RD; endsequence
  sequence s_ack; ##1 REG_ACK; endsequence
  property p_ack; s_req |-> s_ack; endproperty
  property p_quiet; !(REG_WR || REG_RD) |=> !REG_ACK; endproperty
  property p_present; REG_ACK && $past(REG_RD && hit) |-> REG_RDATA[31]; endproperty
  property p_rsvd; REG_ACK && $past(REG_RD) |-> REG_RDATA[30:26] == 5'h00; endproperty
  property p_unmapped; REG_ACK && $past(REG_RD && !hit) |-> REG_RDATA == 32'h0000_0000; endproperty
  property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
  property p_unsel; PORT_STROBE_SEL == 4'h0 |=> OUT_PORT == $past(PORT_LEVEL); endproperty
  // Only judged while all ports are set for strobe and port levels hold, so port level changes cannot explain an edge
  property p_cause;
    $changed(OUT_PORT) && $past(&PORT_STROBE_SEL) && $past(&PORT_STROBE_SEL, 2) &&
      $past(PORT_LEVEL) == $past(PORT_LEVEL, 2)
      |-> $past(DELAY_TICK || DURATION_TICK || EXPOSURE_START || REG_WR, 2);
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after access");
  a_quiet: assert property (p_quiet) else $error("ack without access");
  a_present: assert property (p_present) else $error("presence bit low");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_unsel: assert property (p_unsel) else $error("strobe on unselected port");
  a_cause: assert property (p_cause) else $error("port edge without cause");
endmodule // spg_strobe_properties
bind spg_strobe_top spg_strobe_properties u_props (.CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .EXPOSURE_START(EXPOSURE_START), .DELAY_TICK(DELAY_TICK),
  .DURATION_TICK(DURATION_TICK), .PORT_STROBE_SEL(PORT_STROBE_SEL), .PORT_LEVEL(PORT_LEVEL),
  .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .OUT_PORT(OUT_PORT));
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the four-channel strobe generator.
// Assumes the flash model listens on port 0 and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, reset = 1, wr = 0, rd = 0, exp_s = 0, dtk = 0, utk = 0, ack;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] sel = 4'h0, lvl = 4'hc, outp;
  int width, n_mismatch = 0, cmp_count = 0;
  always #10 clk = ~clk;
  spg_strobe_top u_dut (.CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .EXPOSURE_START(exp_s), .DELAY_TICK(dtk), .DURATION_TICK(utk),
    .PORT_STROBE_SEL(sel), .PORT_LEVEL(lvl), .REG_RDATA(rdata), .REG_ACK(ack), .OUT_PORT(outp));
  spg_flash_model u_flash (.clk(clk), .lvl(outp[0]), .width(width));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic access(logic w, logic [11:0] a, logic [31:0] d);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    step(1);
    wr = 0;
    rd = 0;
    check("ack", ack, 1'b1);
    // Let an edge pass so a following access never re-raises a strobe in this time step
    step(1);
  endtask
  task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp);
    access(0, a, 32'h0000_0000);
    check(what, rdata, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rd_chk("reset", 12'h200 + 12'(4 * i), 32'h8100_0fff);
    access(1, 12'h204, 32'h0000_5123);
    rd_chk("locked", 12'h204, 32'h8100_0fff);
    access(1, 12'h204, 32'h0200_0000);
    rd_chk("enable only", 12'h204, 32'h8300_0fff);
    access(1, 12'h204, 32'hfeff_ffff);
    rd_chk("max", 12'h204, 32'h82ff_ffff);
    access(1, 12'h204, 32'hfe00_1002);
    rd_chk("fields", 12'h204, 32'h8200_1002);
    access(1, 12'h202, 32'h0300_0000);
    rd_chk("unaligned", 12'h202, 32'h0000_0000);
    rd_chk("unmapped", 12'h210, 32'h0000_0000);
    rd_chk("untouched", 12'h200, 32'h8100_0fff);
    sel = 4'h3;
    step(2);
    check("routing", outp, 4'he);
    sel = 4'h0;
    step(2);
    check("unrouted", outp, 4'hc);
    $display("done t_regs");
  endtask
  task automatic t_pulse;
    sel = 4'hf;
    access(1, 12'h200, 32'h0200_0000);
    access(1, 12'h200, 32'h0300_2003);
    step(2);
    pulse(exp_s);
    step(2);
    pulse(dtk);
    step(1);
    pulse(dtk);
    // Last tick is taken and the timer is already active, but the output flop still lags it
    check("held", outp[0], 1'b0);
    step(2);
    check("fired", outp[0], 1'b1);
    repeat (3) begin
      pulse(utk);
      step(1);
    end
    step(1);
    check("ended", outp[0], 1'b0);
    step(1);
    check("width", width, 32'd7);
    $display("done t_pulse");
  endtask
  task automatic t_low;
    access(1, 12'h200, 32'h0200_0001);
    step(1);
    check("idle high", outp[0], 1'b1);
    pulse(exp_s);
    step(1);
    check("active low", outp[0], 1'b0);
    pulse(utk);
    step(2);
    check("back high", outp[0], 1'b1);
    $display("done t_low");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    step(8);
    reset = 0;
    t_regs();
    t_pulse();
    t_low();
    complete_run();
  end
endmodule // tb
`default_nettype wire
